// *** hdl/fsw_pkg.sv ***
// Behaviour
// [R1] Program only whole 64-byte blocks
// [R2] Sixty-four byte holding registers feed programming
// [R3] Table write updates only holding register
// [R4] Software writes control to launch write
// [R5] Core stalls during long write
// [R6] Internal timer ends cycle near 2 ms
// [R7] Holding registers keep contents after programming
// [R8] Software programs each byte at most twice
// [R9] Software erases programmed region first
// [R10] Software loads 64 bytes with auto-increment
// [R11] Software sets program enable before start
// [R12] Keys 55h then AAh precede start
// [R13] Software verifies block by table reads
// [R14] Pointer stays inside target block range
// [R15] Reset during cycle leaves error flag set
// [R16] Start needs unlock sequence just before
// [R17] Unlock key register holds no storage
// [R18] Control bits: erase4 err3 en2 start1
// [R19] Pointer from low, high, upper bytes
// [R20] Software rewrites row as 16 blocks
// [R21] Start only settable, hardware clears it
// [R22] Erase select makes row erase, self-clears
// [R23] Pointer bits 5:0 select holding register
// [R24] Unlock key register reads zero
// [R25] Start ignored while program enable clear
package fsw_pkg;
    localparam int BUF_BYTES = 64;
    localparam int IDX_W = 6;
    localparam int PTR_W = 22;
    localparam real CLK_MHZ = 40.0;
    localparam real PROG_TIME_US = 2000.0;
    localparam int PROG_CYCLES = int'(PROG_TIME_US * CLK_MHZ);
    // Register select codes
    localparam logic [2:0] SEL_PTR_LOW = 3'h0;
    localparam logic [2:0] SEL_PTR_HIGH = 3'h1;
    localparam logic [2:0] SEL_PTR_UPPER = 3'h2;
    localparam logic [2:0] SEL_LATCH = 3'h3;
    localparam logic [2:0] SEL_KEY = 3'h4;
    localparam logic [2:0] SEL_CTRL = 3'h5;
    // Control register fields
    localparam int CTL_ERASE = 4;
    localparam int CTL_ERR = 3;
    localparam int CTL_EN = 2;
    localparam int CTL_START = 1;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    typedef enum logic [1:0] {
        OP_NONE,
        OP_WRITE_KEEP,
        OP_WRITE_INC,
        OP_WRITE_PREINC
    } fsw_tbl_op_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] sel;
        logic [7:0] wdata;
    } fsw_reg_req_t;
    typedef struct packed {
        logic busy;
        logic erase;
        logic [PTR_W-1:0] addr;
    } fsw_flash_cmd_t;
endpackage

// *** hdl/fsw_hold_buf.sv ***
`timescale 1ns/10ps
module fsw_hold_buf
    import fsw_pkg::*;
#(
    parameter int DEPTH = BUF_BYTES,
    parameter int AW = IDX_W
) (
    // Clock
    input wire logic core_clk_i,
    // Write port
    input wire logic wr_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [7:0] wdata_i,
    // Read port
    input wire logic [AW-1:0] raddr_i,
    output logic [7:0] rdata_o
);
    if (DEPTH != (1 << AW)) begin : g_bad_depth
        $error("depth must be 2**AW");
    end
    logic [7:0] mem [DEPTH];
    // No reset: contents survive programming and resets
    // Registered read: one cycle from index to data
    always_ff @(posedge core_clk_i) begin
        if (wr_i) mem[waddr_i] <= wdata_i; // see [R2] [R3] [R7]
        rdata_o <= mem[raddr_i];
    end
endmodule // fsw_hold_buf

// *** hdl/fsw_writer.sv ***
`timescale 1ns/10ps
module fsw_writer
    import fsw_pkg::*;
#(
    parameter int PROG_CNT = PROG_CYCLES
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Reset cause: external pin or watchdog, raised with srst_i
    input wire logic abort_rst_i,
    // Register access from core
    input wire fsw_reg_req_t req_i,
    output logic [7:0] rdata_o,
    // Table write from core
    input wire fsw_tbl_op_t tbl_op_i,
    // Flash array side
    output fsw_flash_cmd_t flash_cmd_o,
    output logic flash_wr_o,
    output logic [IDX_W-1:0] flash_widx_o,
    output logic [7:0] flash_wdata_o,
    input wire logic [IDX_W-1:0] flash_ridx_i,
    // Core stall
    output logic stall_o
);
    if (PROG_CNT < 2) begin : g_bad_cnt
        $error("PROG_CNT too small");
    end
    localparam int CW = $clog2(PROG_CNT + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(PROG_CNT - 1);

    typedef enum logic [1:0] {ST_IDLE, ST_KEY1, ST_ARMED} fsw_key_t;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [PTR_W-1:0] ptr;
    logic [7:0] latch;
    logic erase_sel, err_flag, prog_en, busy;
    logic [CW-1:0] cnt;
    fsw_key_t key_st;
    logic [7:0] rdata;
    fsw_flash_cmd_t cmd;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic logic hit(input fsw_reg_req_t r,
                                 input logic [2:0] s);
        return r.wr && r.sel == s;
    endfunction

    wire ctl_wr = hit(req_i, SEL_CTRL);
    wire key_wr = hit(req_i, SEL_KEY);
    wire start_req = ctl_wr && req_i.wdata[CTL_START] && !busy;
    wire start_ok = start_req && key_st == ST_ARMED
        && prog_en && req_i.wdata[CTL_EN]; // see [R16] [R25]
    wire done = busy && cnt == CNT_LAST; // see [R6]
    wire tbl_wr = tbl_op_i != OP_NONE && !busy;
    wire [PTR_W-1:0] ptr_inc = {ptr[PTR_W-1],
        ptr[PTR_W-2:0] + (PTR_W-1)'(1)};
    wire [PTR_W-1:0] wr_ptr = tbl_op_i == OP_WRITE_PREINC ? ptr_inc : ptr;
    wire [7:0] ctl_val = {3'h0, erase_sel, err_flag, prog_en, busy,
        1'b0}; // see [R18]

    fsw_hold_buf #(.DEPTH(BUF_BYTES), .AW(IDX_W)) u_buf (
        .core_clk_i(core_clk_i),
        .wr_i(tbl_wr), // see [R3]
        .waddr_i(wr_ptr[IDX_W-1:0]), // see [R23]
        .wdata_i(latch),
        .raddr_i(flash_ridx_i),
        .rdata_o(flash_wdata_o)
    );

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = ZERO_BYTE;
        unique case (req_i.sel)
            SEL_PTR_LOW: next_rdata = ptr[7:0];
            SEL_PTR_HIGH: next_rdata = ptr[15:8];
            SEL_PTR_UPPER: next_rdata = {2'h0, ptr[21:16]}; // see [R19]
            SEL_LATCH: next_rdata = latch;
            SEL_CTRL: next_rdata = ctl_val;
            default: next_rdata = ZERO_BYTE; // see [R24] [R17]
        endcase
    end

    // ----------------------------------------
    // Pointer and latch
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ptr <= '0;
            latch <= ZERO_BYTE;
        end else begin
            if (hit(req_i, SEL_PTR_LOW)) ptr[7:0] <= req_i.wdata;
            if (hit(req_i, SEL_PTR_HIGH)) ptr[15:8] <= req_i.wdata;
            if (hit(req_i, SEL_PTR_UPPER))
                ptr[21:16] <= req_i.wdata[5:0]; // see [R19]
            if (hit(req_i, SEL_LATCH)) latch <= req_i.wdata;
            if (tbl_wr && tbl_op_i != OP_WRITE_KEEP) ptr <= ptr_inc;
        end
    end

    // ----------------------------------------
    // Unlock sequence, control, timer
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            key_st <= ST_IDLE;
        end else if (req_i.wr) begin
            // Any other register write in between breaks the sequence; table writes do not
            key_st <= ST_IDLE; // see [R12]
            if (key_wr && req_i.wdata == KEY_FIRST) key_st <= ST_KEY1;
            if (key_wr && req_i.wdata == KEY_SECOND && key_st == ST_KEY1)
                key_st <= ST_ARMED;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            erase_sel <= 1'b0;
            prog_en <= 1'b0;
            busy <= 1'b0;
            cnt <= '0;
            cmd <= '0;
        end else begin
            if (ctl_wr && !busy) begin
                erase_sel <= req_i.wdata[CTL_ERASE];
                prog_en <= req_i.wdata[CTL_EN];
            end
            if (start_ok) begin
                busy <= 1'b1; // see [R4] [R12]
                cnt <= '0;
                cmd.busy <= 1'b1;
                cmd.erase <= req_i.wdata[CTL_ERASE];
                cmd.addr <= ptr; // see [R1] [R14]
            end else if (done) begin
                busy <= 1'b0; // see [R21]
                cmd.busy <= 1'b0;
                if (cmd.erase) erase_sel <= 1'b0; // see [R22]
            end else if (busy) begin
                cnt <= cnt + CW'(1);
            end
        end
    end

    // Error flag survives the aborting reset
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            if (busy && abort_rst_i) err_flag <= 1'b1; // see [R15]
        end else if (start_ok) begin
            err_flag <= 1'b1;
        end else if (done) begin
            err_flag <= 1'b0;
        end else if (ctl_wr && !busy) begin
            err_flag <= req_i.wdata[CTL_ERR];
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic wr_pulse;
    logic [IDX_W-1:0] widx;
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rdata <= ZERO_BYTE;
            wr_pulse <= 1'b0;
            widx <= '0;
        end else begin
            rdata <= next_rdata;
            wr_pulse <= tbl_wr;
            widx <= wr_ptr[IDX_W-1:0];
        end
    end
    assign rdata_o = rdata;
    assign flash_cmd_o = cmd;
    assign stall_o = busy; // see [R5]
    assign flash_wr_o = wr_pulse;
    assign flash_widx_o = widx;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    no_key_start_a: assert property (@(posedge core_clk_i) // see [R16]
        disable iff (srst_i) start_req && key_st != ST_ARMED |=> !busy)
        else $error("start without unlock");
    en_gate_a: assert property (@(posedge core_clk_i) // see [R25]
        disable iff (srst_i) start_req && !prog_en |=> !busy)
        else $error("start while disabled");
    stall_start_a: assert property (@(posedge core_clk_i) // see [R5]
        disable iff (srst_i) start_ok |=> stall_o && cmd.busy)
        else $error("no stall on start");
    start_hold_a: assert property (@(posedge core_clk_i) // see [R21]
        disable iff (srst_i) busy && !done |=> busy)
        else $error("start bit dropped early");
    timer_end_a: assert property (@(posedge core_clk_i) // see [R6]
        disable iff (srst_i) done |=> !busy && !err_flag)
        else $error("cycle did not end");
    erase_clr_a: assert property (@(posedge core_clk_i) // see [R22]
        disable iff (srst_i) done && cmd.erase |=> !erase_sel)
        else $error("erase select not cleared");
    key_read_a: assert property (@(posedge core_clk_i) // see [R24]
        disable iff (srst_i) req_i.sel == SEL_KEY |=> rdata_o == ZERO_BYTE)
        else $error("key register read nonzero");
    err_set_a: assert property (@(posedge core_clk_i) // see [R15]
        busy && abort_rst_i && srst_i |=> err_flag)
        else $error("error flag lost on reset");
    hold_wr_a: assert property (@(posedge core_clk_i) // see [R3]
        disable iff (srst_i) stall_o && tbl_op_i != OP_NONE |=> !flash_wr_o)
        else $error("holding write during cycle");
    cnt_range_a: assert property (@(posedge core_clk_i) // see [R6]
        disable iff (srst_i) busy |-> cnt <= CNT_LAST)
        else $error("timer overrun");
    prog_c: cover property (@(posedge core_clk_i) disable iff (srst_i)
        done && !cmd.erase);
    erase_c: cover property (@(posedge core_clk_i) disable iff (srst_i)
        done && cmd.erase);
    abort_c: cover property (@(posedge core_clk_i)
        busy && srst_i && abort_rst_i);
endmodule // fsw_writer

// *** sim/fsw_flash_model.sv ***
`timescale 1ns/10ps
module fsw_flash_model
    import fsw_pkg::*;
(
    // Clock
    input wire logic core_clk_i,
    // Command and data from the writer
    input wire fsw_flash_cmd_t flash_cmd_i,
    input wire logic [7:0] flash_wdata_i,
    // Holding buffer index
    output logic [IDX_W-1:0] flash_ridx_o
);
    // ------------------------------------------------------------
    // Array capture
    // ------------------------------------------------------------
    logic [7:0] cap [BUF_BYTES];
    logic [IDX_W-1:0] prev_idx;

    initial begin
        flash_ridx_o = '0;
        prev_idx = '0;
    end

    // Index walks all the time; data lags its index by one cycle
    always @(posedge core_clk_i) begin
        flash_ridx_o <= flash_ridx_o + 6'h01;
        prev_idx <= flash_ridx_o;
        if (flash_cmd_i.busy === 1'b1) begin
            if (flash_cmd_i.erase === 1'b1) begin
                cap[prev_idx] <= 8'hFF;
            end else begin
                cap[prev_idx] <= flash_wdata_i;
            end
        end
    end
endmodule // fsw_flash_model

// *** sim/tb_flash_self_program_writer.sv ***
`timescale 1ns/10ps
module tb_flash_self_program_writer;
    import fsw_pkg::*;
    localparam int PCNT = 70;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic abort_rst_i = 1'b0;
    fsw_reg_req_t req = '0;
    fsw_tbl_op_t op = OP_NONE;
    logic [7:0] rdata;
    fsw_flash_cmd_t cmd;
    logic fwr;
    logic stall;
    logic [IDX_W-1:0] widx;
    logic [IDX_W-1:0] ridx;
    logic [7:0] fdata;
    int n_errors = 0;
    int checked = 0;
    int n;

    always #12.5 core_clk_i = ~core_clk_i;

    fsw_writer #(.PROG_CNT(PCNT)) i_dut (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .abort_rst_i(abort_rst_i),
        .req_i(req),
        .rdata_o(rdata),
        .tbl_op_i(op),
        .flash_cmd_o(cmd),
        .flash_wr_o(fwr),
        .flash_widx_o(widx),
        .flash_wdata_o(fdata),
        .flash_ridx_i(ridx),
        .stall_o(stall)
    );

    fsw_flash_model i_flash (
        .core_clk_i(core_clk_i),
        .flash_cmd_i(cmd),
        .flash_wdata_i(fdata),
        .flash_ridx_o(ridx)
    );

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] pat(input int i);
        return 8'(i * 7 + 17);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        @(posedge core_clk_i);
        req <= '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
        @(posedge core_clk_i);
        req <= '0;
    endtask

    task automatic rd(input logic [2:0] s, input logic [7:0] e);
        @(posedge core_clk_i);
        req <= '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 8'h00};
        @(posedge core_clk_i);
        req <= '0;
        #1 chk(rdata, e);
    endtask

    task automatic tw(input fsw_tbl_op_t o, input logic [7:0] d,
                      input logic [5:0] ei);
        logic [5:0] gi;
        wr(SEL_LATCH, d);
        @(posedge core_clk_i);
        op <= o;
        @(posedge core_clk_i);
        op <= OP_NONE;
        gi = 'x;
        repeat (2) begin
            #1 if (fwr === 1'b1) gi = widx;
            @(posedge core_clk_i);
        end
        chk(gi, ei);
    endtask

    task automatic launch(input logic [7:0] c);
        wr(SEL_KEY, KEY_FIRST);
        wr(SEL_KEY, KEY_SECOND);
        wr(SEL_CTRL, c);
    endtask

    task automatic quiet();
        repeat (4) begin
            @(posedge core_clk_i);
            #1 chk(stall, 1'b0);
        end
    endtask

    task automatic run(input logic er, input logic [21:0] a);
        #1;
        n = 0;
        while (stall !== 1'b1 && n < 3) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        chk({cmd.busy, cmd.erase, cmd.addr}, {1'b1, er, a});
        n = 0;
        while (stall === 1'b1 && n < 2 * PCNT) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        chk(n, PCNT);
    endtask

    task automatic finish_test();
        if (n_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge core_clk_i);
        srst_i <= 1'b0;
        wr(SEL_CTRL, 8'h00);
        rd(SEL_CTRL, 8'h00);
        wr(SEL_KEY, 8'h5A);
        rd(SEL_KEY, ZERO_BYTE);
        rd(3'h6, 8'h00);
        wr(SEL_CTRL, 8'hFF);
        rd(SEL_CTRL, 8'h1C);
        wr(SEL_CTRL, 8'h04);
        wr(SEL_PTR_UPPER, 8'hFF);
        rd(SEL_PTR_UPPER, 8'h3F);
        wr(SEL_PTR_UPPER, 8'h01);
        wr(SEL_PTR_HIGH, 8'h12);
        wr(SEL_PTR_LOW, 8'h40);
        for (int i = 0; i < BUF_BYTES; i++) begin
            tw(OP_WRITE_INC, pat(i), 6'(i));
        end
        rd(SEL_PTR_LOW, 8'h80);
        rd(SEL_PTR_HIGH, 8'h12);
        wr(SEL_PTR_LOW, 8'h45);
        tw(OP_WRITE_KEEP, pat(5), 6'h05);
        rd(SEL_PTR_LOW, 8'h45);
        tw(OP_WRITE_PREINC, pat(6), 6'h06);
        rd(SEL_PTR_LOW, 8'h46);
        // Key pair broken by another write
        wr(SEL_KEY, KEY_FIRST);
        wr(SEL_LATCH, 8'h00);
        wr(SEL_KEY, KEY_SECOND);
        wr(SEL_CTRL, 8'h06);
        quiet();
        wr(SEL_CTRL, 8'h00);
        launch(8'h02);
        quiet();
        rd(SEL_CTRL, 8'h00);
        wr(SEL_CTRL, 8'h04);
        wr(SEL_PTR_LOW, 8'h7F);
        launch(8'h06);
        run(1'b0, 22'h01127F);
        rd(SEL_CTRL, 8'h04);
        for (int i = 0; i < BUF_BYTES; i++) begin
            chk(i_flash.cap[i], pat(i));
        end
        wr(SEL_CTRL, 8'h14);
        launch(8'h16);
        run(1'b1, 22'h01127F);
        rd(SEL_CTRL, 8'h04);
        for (int i = 0; i < BUF_BYTES; i++) begin
            chk(i_flash.cap[i], 8'hFF);
        end
        // Reprogram after erase from the untouched holding buffer
        launch(8'h06);
        run(1'b0, 22'h01127F);
        for (int i = 0; i < BUF_BYTES; i++) begin
            chk(i_flash.cap[i], pat(i));
        end
        launch(8'h06);
        // Table write during the long cycle must be ignored
        @(posedge core_clk_i);
        op <= OP_WRITE_INC;
        @(posedge core_clk_i);
        op <= OP_NONE;
        #1 chk(fwr, 1'b0);
        rd(SEL_PTR_LOW, 8'h7F);
        @(posedge core_clk_i);
        srst_i <= 1'b1;
        abort_rst_i <= 1'b1;
        @(posedge core_clk_i);
        srst_i <= 1'b0;
        abort_rst_i <= 1'b0;
        rd(SEL_CTRL, 8'h08);
        chk(stall, 1'b0);
        finish_test();
    end

    initial begin
        #(25 * 20000);
        n_errors++;
        finish_test();
    end
endmodule // tb_flash_self_program_writer
